// >>> logic/nvb_params.svh
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH

// burst field of the mode register write
`define NVB_MR_FULL_BURST_EIGHT 2'h0
`define NVB_MR_PER_COMMAND 2'h1
`define NVB_MR_CHOPPED_BURST_FOUR 2'h2
`define NVB_MR_RESERVED 2'h3
`define NVB_MR_RESET_VALUE 2'h0

// beats per access
`define NVB_BEATS_CHOPPED 4'h4
`define NVB_BEATS_FULL 4'h8

// bank organisation
`define NVB_BANK_GROUPS 3'h4
`define NVB_BANKS_PER_GROUP 3'h4

`endif

// >>> logic/nvb_pkg.sv
package nvb_pkg;

  typedef enum logic [2:0] {
    ST_HOST,
    ST_WAIT_SR,
    ST_BACKUP,
    ST_RESTORE,
    ST_OFF
  } nvb_state_type;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_PIN,
    SRC_CKE,
    SRC_SMBUS
  } nvb_source_type;

endpackage

// >>> logic/nvb_cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvb_params.svh"

module nvb_cmd_decode
  import nvb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // burst setting
  input wire logic [1:0] burst_mode,
  // host command
  input wire logic cmd_valid,
  input wire logic cmd_read_write,
  input wire logic cmd_full_burst,
  input wire logic [1:0] cmd_bank_group,
  input wire logic [1:0] cmd_bank,
  // decoded access
  output logic access_strobe,
  output logic [3:0] access_beats,
  output logic [3:0] access_bank
);

  logic next_strobe;
  logic [3:0] next_beats;
  logic [3:0] next_bank;

  function automatic logic [3:0] beats_for(input logic [1:0] mode,
                                           input logic full);
    unique case (mode)
      `NVB_MR_CHOPPED_BURST_FOUR: beats_for = `NVB_BEATS_CHOPPED;
      `NVB_MR_PER_COMMAND: beats_for = full ? `NVB_BEATS_FULL
                                            : `NVB_BEATS_CHOPPED;
      default: beats_for = `NVB_BEATS_FULL;
    endcase
  endfunction

  always_comb begin
    next_strobe = cmd_valid & cmd_read_write;
    next_beats = access_beats;
    next_bank = access_bank;
    if (cmd_valid) begin
      next_bank = {cmd_bank_group, cmd_bank};
    end
    if (cmd_valid && cmd_read_write) begin
      next_beats = beats_for(burst_mode, cmd_full_burst);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      access_strobe <= 1'b0;
      access_beats <= `NVB_BEATS_FULL;
      access_bank <= 4'h0;
    end else begin
      access_strobe <= next_strobe;
      access_beats <= next_beats;
      access_bank <= next_bank;
    end
  end

  chk_fixed_chop: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    cmd_valid && cmd_read_write && burst_mode == `NVB_MR_CHOPPED_BURST_FOUR
    |=> access_strobe && access_beats == `NVB_BEATS_CHOPPED)
    else $error("fixed chop setting did not give four beats");

  chk_otf_select: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    cmd_valid && cmd_read_write && burst_mode == `NVB_MR_PER_COMMAND
    |=> access_beats == ($past(cmd_full_burst) ? `NVB_BEATS_FULL
                                              : `NVB_BEATS_CHOPPED))
    else $error("per command burst select gave wrong length");

  chk_bank_map: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    cmd_valid |=> access_bank == {$past(cmd_bank_group), $past(cmd_bank)})
    else $error("bank index does not follow group and bank bits");

endmodule

`default_nettype wire

// >>> logic/nvb_handoff.sv
// Functional notes
// - backup on request pin, refresh trigger, falling clock enable or SMBus.
// - in self refresh clock enable stays low; only it and reset matter.
// - SDRAM self refreshes and keeps data while controller copies to flash.
// - on lost power, module saves to flash then shuts down on its own.
// - mode register selects fixed chop of four or fixed burst of eight.
// - per-command burst select picks chop or full burst per access.
// - sixteen banks, four groups of four, by group and bank bits.
`timescale 1ns/100ps
`default_nettype none
`include "nvb_params.svh"

module nvb_handoff
  import nvb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host side control pins
  input wire logic host_rank0_clock_enable,
  input wire logic host_reset_n,
  input wire logic backup_request_n,
  input wire logic async_refresh_trigger,
  input wire logic cke_trigger_enable,
  input wire logic power_lost,
  // sideband commands
  input wire logic smbus_backup_cmd,
  input wire logic smbus_restore_cmd,
  // sdram control pins
  output logic sdram_rank0_clock_enable,
  output logic sdram_reset_n,
  // flash copy engine
  output logic backup_flash_store_start,
  input wire logic backup_flash_store_done,
  output logic restore_start,
  input wire logic restore_done,
  // status
  output logic module_owns_sdram,
  output logic module_shutdown,
  output logic [1:0] backup_source,
  // host commands
  input wire logic mode_register_write,
  input wire logic [1:0] mode_burst_field,
  input wire logic cmd_valid,
  input wire logic cmd_read_write,
  input wire logic cmd_full_burst,
  input wire logic [1:0] cmd_bank_group,
  input wire logic [1:0] cmd_bank,
  // decoded access
  output logic [1:0] burst_mode,
  output logic access_strobe,
  output logic [3:0] access_beats,
  output logic [3:0] access_bank
);

  nvb_state_type state;
  nvb_state_type next_state;
  nvb_source_type source;
  nvb_source_type next_source;
  logic cke_prev;
  logic next_cke_prev;
  logic next_sdram_cke;
  logic next_sdram_reset_n;
  logic next_store_start;
  logic next_restore_start;
  logic next_owns;
  logic next_shutdown;
  logic [1:0] next_burst_mode;
  logic pin_trigger;
  logic cke_trigger;
  logic any_trigger;

  function automatic logic owns(input nvb_state_type s);
    owns = (s == ST_BACKUP) || (s == ST_RESTORE) || (s == ST_OFF);
  endfunction

  // trigger sources
  always_comb begin
    pin_trigger = ~backup_request_n | async_refresh_trigger;
    // falling clock enable means the host just entered self refresh
    cke_trigger = cke_trigger_enable & cke_prev
                  & ~host_rank0_clock_enable;
    any_trigger = pin_trigger | cke_trigger | smbus_backup_cmd;
    next_cke_prev = host_rank0_clock_enable;
  end

  // ownership state machine
  always_comb begin
    next_state = state;
    next_source = source;
    next_store_start = 1'b0;
    next_restore_start = 1'b0;
    unique case (state)
      ST_HOST: begin
        if (any_trigger) begin
          next_source = pin_trigger ? SRC_PIN
                      : (cke_trigger ? SRC_CKE : SRC_SMBUS);
          // copying is only safe once the array is self refreshing
          if (!host_rank0_clock_enable) begin
            next_state = ST_BACKUP;
            next_store_start = 1'b1;
          end else begin
            next_state = ST_WAIT_SR;
          end
        end else if (smbus_restore_cmd && !host_rank0_clock_enable) begin
          next_state = ST_RESTORE;
          next_restore_start = 1'b1;
        end
      end
      ST_WAIT_SR: begin
        if (!host_rank0_clock_enable) begin
          next_state = ST_BACKUP;
          next_store_start = 1'b1;
        end
      end
      ST_BACKUP: begin
        if (backup_flash_store_done) begin
          // on reserve energy nothing will reclaim the array
          next_state = power_lost ? ST_OFF : ST_HOST;
        end
      end
      ST_RESTORE: begin
        if (restore_done) begin
          next_state = ST_HOST;
        end
      end
      ST_OFF: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // pin drive, aligned with the registered state
  always_comb begin
    next_owns = owns(next_state);
    // held low for the whole ownership window
    next_sdram_cke = next_owns ? 1'b0
                   : host_rank0_clock_enable;
    // driven low by the module only during sys_rst, so restored data survives
    next_sdram_reset_n = host_reset_n;
    next_shutdown = (next_state == ST_OFF);
  end

  // burst setting
  always_comb begin
    next_burst_mode = burst_mode;
    if (mode_register_write && mode_burst_field != `NVB_MR_RESERVED) begin
      next_burst_mode = mode_burst_field;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_HOST;
      source <= SRC_NONE;
      cke_prev <= 1'b0;
      sdram_rank0_clock_enable <= 1'b0;
      sdram_reset_n <= 1'b0;
      backup_flash_store_start <= 1'b0;
      restore_start <= 1'b0;
      module_owns_sdram <= 1'b0;
      module_shutdown <= 1'b0;
      burst_mode <= `NVB_MR_RESET_VALUE;
    end else begin
      state <= next_state;
      source <= next_source;
      cke_prev <= next_cke_prev;
      sdram_rank0_clock_enable <= next_sdram_cke;
      sdram_reset_n <= next_sdram_reset_n;
      backup_flash_store_start <= next_store_start;
      restore_start <= next_restore_start;
      module_owns_sdram <= next_owns;
      module_shutdown <= next_shutdown;
      burst_mode <= next_burst_mode;
    end
  end

  assign backup_source = source;

  nvb_cmd_decode u_decode (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .burst_mode(burst_mode),
    .cmd_valid(cmd_valid),
    .cmd_read_write(cmd_read_write),
    .cmd_full_burst(cmd_full_burst),
    .cmd_bank_group(cmd_bank_group),
    .cmd_bank(cmd_bank),
    .access_strobe(access_strobe),
    .access_beats(access_beats),
    .access_bank(access_bank)
  );

  chk_trigger_start: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state == ST_HOST && any_trigger && !host_rank0_clock_enable
    |=> backup_flash_store_start && module_owns_sdram
        ##1 !backup_flash_store_start)
    else $error("trigger in self refresh did not start a backup");

  chk_cke_held: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    module_owns_sdram |-> !sdram_rank0_clock_enable)
    else $error("clock enable high while the module owns the array");

  chk_reset_follow: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !$past(sys_rst) |-> sdram_reset_n == $past(host_reset_n))
    else $error("sdram reset does not follow the host reset");

  chk_backup_wait: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state == ST_BACKUP && !backup_flash_store_done
    |=> state == ST_BACKUP && module_owns_sdram)
    else $error("backup left before the flash copy finished");

  chk_power_off: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state == ST_BACKUP && backup_flash_store_done && power_lost
    |=> module_shutdown [*3])
    else $error("no shutdown after backup on lost power");

  chk_hold_owned: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state == ST_RESTORE && !restore_done
    |=> module_owns_sdram && !sdram_rank0_clock_enable)
    else $error("array released before restore completed");

  chk_release_host: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    state == ST_RESTORE && restore_done
    |=> !module_owns_sdram && state == ST_HOST)
    else $error("array not handed back after restore");

endmodule

`default_nettype wire

// >>> testbench/nvb_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module nvb_host_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bench control
  input wire logic quiesce,
  input wire logic slow,
  // module status
  input wire logic module_owns_sdram,
  input wire logic module_shutdown,
  // pins to the module
  output logic host_rank0_clock_enable,
  output logic host_reset_n
);
  logic want_low;
  logic want_low_q;
  // power warning stops traffic, then self refresh entry
  assign want_low = quiesce | module_owns_sdram | module_shutdown;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      want_low_q <= 1'h0;
      host_rank0_clock_enable <= 1'h1;
    end else begin
      want_low_q <= want_low;
      // leave self refresh only once released; slow costs a cycle
      host_rank0_clock_enable <= slow ? !want_low_q : !want_low;
    end
  end
  // never pulsed: restored contents would be lost
  assign host_reset_n = 1'h1;
endmodule

`default_nettype wire

// >>> testbench/nvb_handoff_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvb_params.svh"

module nvb_handoff_tb_top;
  import nvb_pkg::*;
  logic sys_clk, sys_rst, quiesce, slow, host_rank0_clock_enable;
  logic host_reset_n, backup_request_n, async_refresh_trigger;
  logic cke_trigger_enable, power_lost, smbus_backup_cmd, smbus_restore_cmd;
  logic backup_flash_store_done, restore_done, sdram_rank0_clock_enable;
  logic sdram_reset_n, backup_flash_store_start, restore_start;
  logic module_owns_sdram, module_shutdown, access_strobe;
  logic mode_register_write, cmd_valid, cmd_read_write, cmd_full_burst;
  logic [1:0] backup_source, mode_burst_field, cmd_bank_group, cmd_bank;
  logic [1:0] burst_mode, mode_now;
  logic [3:0] access_beats, access_bank;
  logic [7:0] exp_q[$];
  int miscompares, checks_done;

  nvb_handoff uut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .host_rank0_clock_enable(host_rank0_clock_enable),
    .host_reset_n(host_reset_n),
    .backup_request_n(backup_request_n),
    .async_refresh_trigger(async_refresh_trigger),
    .cke_trigger_enable(cke_trigger_enable),
    .power_lost(power_lost),
    .smbus_backup_cmd(smbus_backup_cmd),
    .smbus_restore_cmd(smbus_restore_cmd),
    .sdram_rank0_clock_enable(sdram_rank0_clock_enable),
    .sdram_reset_n(sdram_reset_n),
    .backup_flash_store_start(backup_flash_store_start),
    .backup_flash_store_done(backup_flash_store_done),
    .restore_start(restore_start),
    .restore_done(restore_done),
    .module_owns_sdram(module_owns_sdram),
    .module_shutdown(module_shutdown),
    .backup_source(backup_source),
    .mode_register_write(mode_register_write),
    .mode_burst_field(mode_burst_field),
    .cmd_valid(cmd_valid),
    .cmd_read_write(cmd_read_write),
    .cmd_full_burst(cmd_full_burst),
    .cmd_bank_group(cmd_bank_group),
    .cmd_bank(cmd_bank),
    .burst_mode(burst_mode),
    .access_strobe(access_strobe),
    .access_beats(access_beats),
    .access_bank(access_bank)
  );
  nvb_host_model host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .quiesce(quiesce), .slow(slow),
    .module_owns_sdram(module_owns_sdram), .module_shutdown(module_shutdown),
    .host_rank0_clock_enable(host_rank0_clock_enable),
    .host_reset_n(host_reset_n)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // strobe lands one cycle after the command; look mid-cycle
  always @(negedge sys_clk) begin
    if (!sys_rst && access_strobe === 1'h1) begin
      if (exp_q.size() == 0)
        chk(8'hFF, 8'h00);
      else
        chk({access_beats, access_bank}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  task automatic cmd_phase();
    logic [31:0] v;
    logic [3:0] beats;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      mode_register_write <= 1'h1;
      mode_burst_field <= m[1:0];
      cmd_valid <= 1'h0;
      if (m != 3)
        mode_now = m[1:0];
      @(posedge sys_clk);
      mode_register_write <= 1'h0;
      #1 chk(burst_mode, mode_now);
      repeat (24) begin
        @(posedge sys_clk);
        v = $urandom;
        beats = (mode_now == 2'h0 || (mode_now == 2'h1 && v[2])) ?
          `NVB_BEATS_FULL : `NVB_BEATS_CHOPPED;
        {cmd_bank, cmd_bank_group, cmd_full_burst, cmd_read_write,
          cmd_valid} <= v[6:0];
        if (v[0] && v[1])
          exp_q.push_back({beats, v[4:3], v[6:5]});
      end
      @(posedge sys_clk);
      cmd_valid <= 1'h0;
    end
    repeat (3) @(posedge sys_clk);
    chk(8'(exp_q.size()), 8'h00);
  endtask

  task automatic run_backup(input int kind, input logic [1:0] src,
                            input logic lost);
    int n;
    slow <= !(kind inside {2, 6}) && $urandom_range(1) == 1;
    quiesce <= 1'h1;
    cke_trigger_enable <= kind == 2;
    // early pin trigger while still active makes the module wait
    backup_request_n <= kind != 6;
    power_lost <= lost;
    @(posedge sys_clk);
    if (!(kind inside {2, 6})) begin
      repeat (2) @(posedge sys_clk);
      backup_request_n <= kind != 1;
      async_refresh_trigger <= kind == 3;
      smbus_backup_cmd <= kind == 4;
      smbus_restore_cmd <= kind == 5;
    end
    @(posedge sys_clk);
    backup_request_n <= 1'h1;
    async_refresh_trigger <= 1'h0;
    smbus_backup_cmd <= 1'h0;
    smbus_restore_cmd <= 1'h0;
    cke_trigger_enable <= 1'h0;
    #1 chk({backup_flash_store_start, restore_start},
      kind == 5 ? 8'h01 : 8'h02);
    chk({module_owns_sdram, sdram_rank0_clock_enable, backup_source},
      {4'h0, 2'h2, src});
    n = $urandom_range(9, 2);
    // a second trigger mid-copy must be ignored
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      backup_request_n <= i != 0;
      #1 chk({backup_flash_store_start, restore_start, module_owns_sdram,
        sdram_rank0_clock_enable}, 8'h02);
    end
    backup_flash_store_done <= kind != 5;
    restore_done <= kind == 5;
    quiesce <= 1'h0;
    @(posedge sys_clk);
    backup_flash_store_done <= 1'h0;
    restore_done <= 1'h0;
    #1 chk({module_owns_sdram, module_shutdown}, {6'h0, lost, lost});
    repeat (4) @(posedge sys_clk);
    #1 chk({sdram_rank0_clock_enable, sdram_reset_n, module_shutdown},
      {5'h0, !lost, 1'h1, lost});
  endtask

  initial begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    backup_request_n = 1'h1;
    {quiesce, slow, async_refresh_trigger, cke_trigger_enable, power_lost,
      smbus_backup_cmd, smbus_restore_cmd, backup_flash_store_done,
      restore_done, mode_register_write, cmd_valid, cmd_read_write,
      cmd_full_burst, mode_burst_field, cmd_bank_group, cmd_bank} = '0;
    mode_now = 2'h0;
    void'($urandom(32'h58CB));
    repeat (12) @(posedge sys_clk);
    #1 chk({module_owns_sdram, module_shutdown, backup_source, access_strobe,
      burst_mode}, 8'h00);
    chk({access_beats, sdram_reset_n, backup_flash_store_start,
      restore_start}, {`NVB_BEATS_FULL, 3'h0});
    @(posedge sys_clk);
    sys_rst <= 1'h0;
    cmd_phase();
    run_backup(1, 2'h1, 1'h0);
    run_backup(3, 2'h1, 1'h0);
    run_backup(2, 2'h2, 1'h0);
    run_backup(6, 2'h1, 1'h0);
    run_backup(4, 2'h3, 1'h0);
    run_backup(5, 2'h3, 1'h0);
    run_backup(1, 2'h1, 1'h1);
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    power_lost <= 1'h0;
    @(posedge sys_clk);
    #1 chk({module_owns_sdram, module_shutdown}, 8'h00);
    @(posedge sys_clk);
    sys_rst <= 1'h0;
    cmd_phase();
    stop_test();
  end
endmodule

`default_nettype wire
